// *** logic/acc_defines.vh ***
// constants for the conversion controller: register offsets, fields, timing
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

// ----------------------------------------------------------------
// register indices (word offsets on the plain register port)
// ----------------------------------------------------------------
`define ACC_A_CTRL     6'h00
`define ACC_A_MODE     6'h01
`define ACC_A_EXTMODE  6'h02
`define ACC_A_CHEN     6'h03
`define ACC_A_CHDIS    6'h04
`define ACC_A_CHSTAT   6'h05
`define ACC_A_STATUS   6'h06
`define ACC_A_OVER     6'h07
`define ACC_A_LAST     6'h08
`define ACC_A_TEMP     6'h09
`define ACC_A_CDR0     6'h10
`define ACC_A_CDR_LAST 6'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACC_CTRL_START     0
`define ACC_MODE_LOW_RESOLUTION_SELECT    4
`define ACC_MODE_DIV_LO    8
`define ACC_MODE_DIV_HI    15
`define ACC_MODE_TRK_LO    24
`define ACC_MODE_TRK_HI    27
`define ACC_EMR_TAG        24
`define ACC_LAST_CHN_LO    12
`define ACC_STAT_RESULT_READY_FLAG      24
`define ACC_STAT_GENERAL_OVERRUN_FLAG     25
`define ACC_STAT_BUSY      26
`define ACC_TEMP_ON        4

// ----------------------------------------------------------------
// reset values, cell timing and the on-die sensor channel index
// ----------------------------------------------------------------
`define ACC_MODE_RESET     32'h0000_0000
`define ACC_CONV_CYCLES    4'hA
`define ACC_SENSOR_CH      5'h10

`endif

// *** logic/acc_result_mem.v ***
// per-channel result store with registered read port
`timescale 1ns/1ps
module acc_result_mem #(
  parameter DEPTH = 17,
  parameter AW    = 5,
  parameter DW    = 10
) (
  // clock
  input  wire          clk,
  // write side
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // read side
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end

endmodule

// *** logic/acc_ctrl.v ***
// conversion controller: clock divider, sequencer, result and flag registers
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_ctrl #(
  parameter NCH = 17,
  parameter DW  = 10
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // peripheral clock gate from the power manager
  input  wire        periph_clk_en,
  // register port
  input  wire [5:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // analog cell
  output reg  [4:0]  mux_sel,
  output reg  [16:0] pin_route,
  output reg         cell_track,
  output reg         cell_convert,
  output reg         conv_clk_en,
  input  wire [9:0]  cell_data,
  output reg         temp_sensor_power_on,
  // system
  output reg         dma_req,
  output reg         irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0]     mode_r;
  reg            tag_r;
  reg [NCH-1:0]  chen_r;
  reg [NCH-1:0]  eoc_r;
  reg [NCH-1:0]  ovre_r;
  reg            result_ready_flag_r;
  reg            general_overrun_flag_r;
  reg [NCH-1:0]  ier_r;
  reg            temp_on_r;
  reg [DW-1:0]   last_data_r;
  reg [4:0]      last_ch_r;
  reg            result_ready_flag_d_r;
  reg            start_pend_r;

  wire [7:0] div_field = mode_r[`ACC_MODE_DIV_HI:`ACC_MODE_DIV_LO];
  wire [3:0] trk_field = mode_r[`ACC_MODE_TRK_HI:`ACC_MODE_TRK_LO];
  wire       low_resolution_select    = mode_r[`ACC_MODE_LOW_RESOLUTION_SELECT];

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  reg [8:0] div_cnt_r;
  wire      ctick = periph_clk_en && (div_cnt_r == {div_field, 1'b1});

  always @(posedge clk) begin
    if (reset)
      div_cnt_r <= 9'h000;
    else if (!periph_clk_en || ctick)
      div_cnt_r <= 9'h000;
    else
      div_cnt_r <= div_cnt_r + 9'h001;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam S_IDLE = 2'b00;
  localparam S_RUN  = 2'b01;

  reg [1:0]  state_r;
  reg [4:0]  trk_ch_r;
  reg        trk_act_r;
  reg [3:0]  trk_cnt_r;
  reg [4:0]  cnv_ch_r;
  reg        cnv_act_r;
  reg [3:0]  cnv_cnt_r;

  // next enabled channel at or above a given index; NCH when none
  function [4:0] next_ch;
    input [NCH-1:0] en;
    input [4:0]     from;
    integer         i;
    reg             found;
    begin
      next_ch = NCH[4:0];
      found   = 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        if (!found && en[i] && (i >= from)) begin
          next_ch = i[4:0];
          found   = 1'b1;
        end
      end
    end
  endfunction

  wire [4:0] first_ch = next_ch(chen_r, 5'h00);
  wire [4:0] succ_ch  = next_ch(chen_r, trk_ch_r + 5'h01);
  wire       trk_done = trk_act_r && (trk_cnt_r >= trk_field);
  wire       cnv_done = cnv_act_r && (cnv_cnt_r == `ACC_CONV_CYCLES - 4'h1);
  // tracking may only hand over once the previous conversion finishes
  wire       handover = ctick && trk_done && (!cnv_act_r || cnv_done);
  wire       complete = ctick && cnv_done;

  // 8-bit mode drops two lsbs, top bits read zero
  wire [DW-1:0] res_fmt = low_resolution_select ? {2'b00, cell_data[9:2]} : cell_data;

  always @(posedge clk) begin
    if (reset) begin
      state_r   <= S_IDLE;
      trk_ch_r  <= 5'h00;
      trk_act_r <= 1'b0;
      trk_cnt_r <= 4'h0;
      cnv_ch_r  <= 5'h00;
      cnv_act_r <= 1'b0;
      cnv_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_pend_r && periph_clk_en && first_ch != NCH[4:0]) begin
            state_r   <= S_RUN;
            trk_ch_r  <= first_ch;
            trk_act_r <= 1'b1;
            trk_cnt_r <= 4'h0;
          end
        end
        S_RUN: begin
          if (ctick) begin
            if (trk_act_r && !trk_done)
              trk_cnt_r <= trk_cnt_r + 4'h1;
            if (cnv_act_r && !cnv_done)
              cnv_cnt_r <= cnv_cnt_r + 4'h1;
            if (handover) begin
              cnv_ch_r  <= trk_ch_r;
              cnv_act_r <= 1'b1;
              cnv_cnt_r <= 4'h0;
              trk_cnt_r <= 4'h0;
              trk_ch_r  <= succ_ch;
              trk_act_r <= (succ_ch != NCH[4:0]);
            end else if (complete) begin
              cnv_act_r <= 1'b0;
            end
            if (complete && !trk_act_r)
              state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result store
  // ----------------------------------------------------------------
  wire       cdr_hit = (reg_addr >= `ACC_A_CDR0) && (reg_addr <= `ACC_A_CDR_LAST);
  // result words sit at consecutive indices from the first channel's word
  wire [5:0] cdr_off = reg_addr - `ACC_A_CDR0;
  wire [4:0] cdr_idx = cdr_off[4:0];
  wire [DW-1:0] mem_rdata;

  acc_result_mem #(
    .DEPTH (NCH),
    .AW    (5),
    .DW    (DW)
  ) u_mem (
    .clk   (clk),
    .we    (complete),
    .waddr (cnv_ch_r),
    .wdata (res_fmt),
    .raddr (cdr_idx),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // flags and configuration
  // ----------------------------------------------------------------
  wire rd_status = reg_rd && (reg_addr == `ACC_A_STATUS);
  wire rd_over   = reg_rd && (reg_addr == `ACC_A_OVER);
  wire rd_last   = reg_rd && (reg_addr == `ACC_A_LAST);
  wire rd_cdr    = reg_rd && cdr_hit;
  wire [NCH-1:0] done_vec = complete ? ({{(NCH-1){1'b0}}, 1'b1} << cnv_ch_r)
                                     : {NCH{1'b0}};
  wire [NCH-1:0] rd_vec   = rd_cdr ? ({{(NCH-1){1'b0}}, 1'b1} << cdr_idx)
                                   : {NCH{1'b0}};
  // per-channel irq enables are written at the first result word's offset (ACC_A_CDR0)
  wire wr = reg_wr;

  always @(posedge clk) begin
    if (reset) begin
      mode_r       <= `ACC_MODE_RESET;
      tag_r        <= 1'b0;
      chen_r       <= {NCH{1'b0}};
      eoc_r        <= {NCH{1'b0}};
      ovre_r       <= {NCH{1'b0}};
      result_ready_flag_r       <= 1'b0;
      general_overrun_flag_r      <= 1'b0;
      ier_r        <= {NCH{1'b0}};
      temp_on_r    <= 1'b0;
      last_data_r  <= {DW{1'b0}};
      last_ch_r    <= 5'h00;
      start_pend_r <= 1'b0;
    end else begin
      // writes land regardless of the peripheral clock gate
      if (wr && reg_addr == `ACC_A_MODE)
        mode_r <= reg_wdata;
      if (wr && reg_addr == `ACC_A_EXTMODE)
        tag_r <= reg_wdata[`ACC_EMR_TAG];
      if (wr && reg_addr == `ACC_A_TEMP)
        temp_on_r <= reg_wdata[`ACC_TEMP_ON];
      if (wr && reg_addr == `ACC_A_CHEN)
        chen_r <= chen_r | reg_wdata[NCH-1:0];
      else if (wr && reg_addr == `ACC_A_CHDIS)
        chen_r <= chen_r & ~reg_wdata[NCH-1:0];
      if (wr && reg_addr == `ACC_A_CDR0)
        ier_r <= reg_wdata[NCH-1:0];
      // start held until the sequencer takes it; later ones ignored while busy
      if (wr && reg_addr == `ACC_A_CTRL && reg_wdata[`ACC_CTRL_START] && state_r == S_IDLE)
        start_pend_r <= 1'b1;
      else if (state_r == S_RUN)
        start_pend_r <= 1'b0;
      // a start with no channel enabled is dropped, not kept for a later enable
      else if (first_ch == NCH[4:0])
        start_pend_r <= 1'b0;
      if (complete) begin
        last_data_r <= res_fmt;
        last_ch_r   <= cnv_ch_r;
      end
      // set wins over a clear in the same cycle
      eoc_r   <= (eoc_r & ~rd_vec) | done_vec;
      ovre_r  <= (rd_over ? {NCH{1'b0}} : ovre_r) | (done_vec & eoc_r);
      result_ready_flag_r  <= (result_ready_flag_r && !rd_last) || complete;
      general_overrun_flag_r <= (general_overrun_flag_r && !rd_status) || (complete && result_ready_flag_r);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  reg [31:0] rd_nxt;
  reg        cdr_rd_r;
  reg [31:0] rdata_r;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr)
      `ACC_A_MODE:    rd_nxt = mode_r;
      `ACC_A_EXTMODE: rd_nxt[`ACC_EMR_TAG] = tag_r;
      `ACC_A_CHSTAT:  rd_nxt[NCH-1:0] = chen_r;
      `ACC_A_STATUS: begin
        rd_nxt[NCH-1:0]         = eoc_r;
        rd_nxt[`ACC_STAT_RESULT_READY_FLAG]  = result_ready_flag_r;
        rd_nxt[`ACC_STAT_GENERAL_OVERRUN_FLAG] = general_overrun_flag_r;
        rd_nxt[`ACC_STAT_BUSY]  = (state_r != S_IDLE);
      end
      `ACC_A_OVER:    rd_nxt[NCH-1:0] = ovre_r;
      `ACC_A_LAST: begin
        rd_nxt[DW-1:0] = last_data_r;
        if (tag_r)
          rd_nxt[`ACC_LAST_CHN_LO+4:`ACC_LAST_CHN_LO] = last_ch_r;
      end
      `ACC_A_TEMP:    rd_nxt[`ACC_TEMP_ON] = temp_on_r;
      default:        rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      rdata_r  <= 32'h0000_0000;
      cdr_rd_r <= 1'b0;
    end else begin
      cdr_rd_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      if (reg_rd && cdr_hit && cdr_idx < NCH[4:0])
        cdr_rd_r <= 1'b1;
      else if (reg_rd)
        rdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data select
  // ----------------------------------------------------------------
  // result words come out of the store's own read register, one cycle
  // after the strobe like every other word; both inputs here are flops
  always @* begin
    if (cdr_rd_r)
      reg_rdata = {{(32-DW){1'b0}}, mem_rdata};
    else
      reg_rdata = rdata_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      mux_sel              <= 5'h00;
      pin_route            <= 17'h00000;
      cell_track           <= 1'b0;
      cell_convert         <= 1'b0;
      conv_clk_en          <= 1'b0;
      temp_sensor_power_on <= 1'b0;
      result_ready_flag_d_r             <= 1'b0;
      dma_req              <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      mux_sel              <= trk_ch_r;       // index 16 is the on-die sensor
      pin_route            <= chen_r;
      cell_track           <= trk_act_r;
      cell_convert         <= cnv_act_r;
      conv_clk_en          <= ctick;
      temp_sensor_power_on <= temp_on_r;
      result_ready_flag_d_r             <= result_ready_flag_r;
      dma_req              <= result_ready_flag_r && !result_ready_flag_d_r;
      irq                  <= |(eoc_r & ier_r) || result_ready_flag_r;
    end
  end

endmodule

// *** tb/acc_cell_model.sv ***
// analog cell and multiplexer stand-in
`timescale 1ns/1ps
module acc_cell_model (
  // clock
  input  wire       clk,
  // controller side
  input  wire [4:0] mux_sel,
  input  wire       cell_track,
  input  wire       cell_convert,
  output reg  [9:0] cell_data
);
  reg [4:0] ch_r = 5'h00;
  reg [4:0] sel_r = 5'h00;
  reg       trk_r = 1'b0;
  initial cell_data = 10'h155;
  // track stays high across back to back channels: the tracked channel
  // enters conversion when the selector moves on while tracking
  always @(posedge clk) begin
    trk_r <= cell_track;
    sel_r <= mux_sel;
    if (trk_r && mux_sel != sel_r) begin
      ch_r <= sel_r;
    end
    // no stale sample outside a conversion
    if (cell_convert) begin
      cell_data <= {5'h15, ch_r};
    end else begin
      cell_data <= ~cell_data;
    end
  end
endmodule

// *** tb/acc_ctrl_asserts.sv ***
// port checker for the conversion controller
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_ctrl_asserts (
  // clock and reset
  input wire        clk,
  input wire        reset,
  // watched ports
  input wire        periph_clk_en,
  input wire [5:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [16:0] pin_route,
  input wire        cell_track,
  input wire        cell_convert,
  input wire        conv_clk_en,
  input wire        temp_sensor_power_on,
  input wire        dma_req
);
  reg [7:0] div_r;
  reg       low_resolution_select_r;
  reg [4:0] tick_r;
  always @(posedge clk) begin
    if (reset) begin
      div_r    <= 8'h00;
      low_resolution_select_r <= 1'b0;
    end else if (reg_wr && reg_addr == `ACC_A_MODE) begin
      div_r    <= reg_wdata[`ACC_MODE_DIV_HI:`ACC_MODE_DIV_LO];
      low_resolution_select_r <= reg_wdata[`ACC_MODE_LOW_RESOLUTION_SELECT];
    end
  end
  // back to back channels may keep convert high over two conversions
  always @(posedge clk) begin
    if (reset || !cell_convert) begin
      tick_r <= 5'h00;
    end else if (conv_clk_en) begin
      tick_r <= tick_r + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_gap;
    !conv_clk_en [*3];
  endsequence
  sequence s_last_rd;
    $past(reg_rd) && $past(reg_addr) == `ACC_A_LAST;
  endsequence
  a_div_gap: assert property ((conv_clk_en && div_r == 8'h01) |=> s_gap)
    else $error("conversion tick spacing wrong");
  a_conv_len: assert property ($fell(cell_convert) |-> tick_r == 5'h0A || tick_r == 5'h14)
    else $error("conversion tick count wrong");
  a_trk_first: assert property ($rose(cell_convert) |-> $past(cell_track))
    else $error("conversion without tracking");
  a_low_top: assert property ((s_last_rd and low_resolution_select_r) |-> reg_rdata[9:8] == 2'h0)
    else $error("low resolution top bits set");
  a_dma_once: assert property (dma_req |=> !dma_req)
    else $error("dma request longer than one cycle");
  a_route_on: assert property ((reg_wr && reg_addr == `ACC_A_CHEN) |->
    ##2 (&(pin_route | ~$past(reg_wdata[16:0], 2)))) else $error("enabled pin not routed");
  a_gated: assert property ((!periph_clk_en && !cell_convert) |=> !cell_convert)
    else $error("conversion while clock gated");
  a_temp_pwr: assert property ((reg_wr && reg_addr == `ACC_A_TEMP) |->
    ##2 temp_sensor_power_on == $past(reg_wdata[`ACC_TEMP_ON], 2))
    else $error("sensor power wrong");
endmodule
bind acc_ctrl acc_ctrl_asserts acc_ctrl_asserts_inst (.clk, .reset, .periph_clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_route, .cell_track, .cell_convert,
  .conv_clk_en, .temp_sensor_power_on, .dma_req);

// *** tb/acc_ctrl_tb_top.sv ***
// self-checking bench for the conversion controller
`timescale 1ns/1ps
module acc_ctrl_tb_top;
  typedef struct packed {
    logic [4:0]  ch;
    logic        lo;
    logic        tag;
    logic [3:0]  trk;
    logic [31:0] exp;
  } acc_row_t;
  // last-result word from sample {5'h15, ch}
  acc_row_t   rows [0:3] = '{'{5'h00, 1'b0, 1'b0, 4'h0, 32'h0000_02A0},
    '{5'h05, 1'b1, 1'b0, 4'h3, 32'h0000_00A9}, '{5'h10, 1'b0, 1'b1, 4'hF, 32'h0001_02B0},
    '{5'h03, 1'b1, 1'b1, 4'h1, 32'h0000_30A8}};
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         periph_clk_en = 1'b1;
  reg  [5:0]  reg_addr = 6'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire [4:0]  mux_sel;
  wire [16:0] pin_route;
  wire [9:0]  cell_data;
  wire        cell_track, cell_convert, conv_clk_en, temp_sensor_power_on, dma_req, irq;
  integer     error_cnt = 0, num_checks = 0, cyc = 0, dma_n = 0, dma0, i;
  reg  [31:0] d, s;
  acc_ctrl acc_ctrl_inst (.clk, .reset, .periph_clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mux_sel, .pin_route, .cell_track, .cell_convert, .conv_clk_en,
    .cell_data, .temp_sensor_power_on, .dma_req, .irq);
  acc_cell_model acc_cell_model_inst (.clk, .mux_sel, .cell_track, .cell_convert, .cell_data);
  always #4 clk = ~clk;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dma_req === 1'b1) dma_n <= dma_n + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  task wr(input [5:0] a, input [31:0] v);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [31:0] m);
    begin
      num_checks = num_checks + 1;
      if ((got & m) !== (exp & m)) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t got %h want %h", $time, got & m, exp & m);
      end
    end
  endtask
  task rdchk(input [5:0] a, input [31:0] exp, input [31:0] m);
    begin
      rd(a);
      chk(d, exp, m);
    end
  endtask
  // a status read clears the general overrun flag, so the polled words are gathered
  task run;
    begin
      wr(6'h00, 32'h1);
      s = 32'h0;
      d = 32'h0400_0000;
      for (i = 0; i < 300 && d[26] !== 1'b0; i = i + 1) begin
        rd(6'h06);
        s = s | d;
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdchk(6'h01, 32'h0, 32'hFFFF_FFFF);
    rdchk(6'h06, 32'h0, 32'hFFFF_FFFF);
    rdchk(6'h3F, 32'h0, 32'hFFFF_FFFF);
    chk({15'h0, pin_route}, 32'h0, 32'h1_FFFF);
    $display("test reset done");
    periph_clk_en <= 1'b0;
    wr(6'h01, 32'h0000_0100);
    wr(6'h03, 32'h1);
    wr(6'h00, 32'h1);
    repeat (100) @(posedge clk);
    rdchk(6'h06, 32'h0, 32'h0100_0001);
    rdchk(6'h01, 32'h0000_0100, 32'hFFFF_FFFF);
    chk({15'h0, pin_route}, 32'h1, 32'h1_FFFF);
    wr(6'h04, 32'h1);
    periph_clk_en <= 1'b1;
    $display("test gated done");
    wr(6'h09, 32'h10);
    repeat (50) @(posedge clk);
    dma0 = dma_n;
    for (int r = 0; r < 4; r++) begin
      wr(6'h01, {4'h0, rows[r].trk, 8'h00, 8'h01, 3'h0, rows[r].lo, 4'h0});
      wr(6'h02, {7'h0, rows[r].tag, 24'h0});
      wr(6'h03, 32'h1 << rows[r].ch);
      run;
      chk(s, 32'h0100_0000 | (32'h1 << rows[r].ch), 32'h0101_FFFF);
      chk({31'h0, irq}, 32'h1, 32'h1);
      rdchk(6'h08, rows[r].exp, 32'h0001_F3FF);
      rdchk(6'h10 + rows[r].ch, rows[r].exp, 32'h3FF);
      rdchk(6'h06, 32'h0, 32'h0101_FFFF);
      chk({31'h0, irq}, 32'h0, 32'h1);
      chk(dma_n - dma0, r + 1, 32'hFF);
      wr(6'h04, 32'h1 << rows[r].ch);
    end
    $display("test rows done");
    wr(6'h01, 32'h0300_0100);
    wr(6'h02, 32'h0100_0000);
    wr(6'h03, 32'h84);
    wr(6'h10, 32'h84);
    run;
    chk(s, 32'h0300_0084, 32'h0301_FFFF);
    rdchk(6'h08, 32'h0000_72A7, 32'h0001_F3FF);
    rdchk(6'h05, 32'h84, 32'h1_FFFF);
    chk({31'h0, irq}, 32'h1, 32'h1);
    run;
    chk(s, 32'h0200_0000, 32'h0200_0000);
    rdchk(6'h07, 32'h84, 32'h1_FFFF);
    rdchk(6'h07, 32'h0, 32'h1_FFFF);
    rdchk(6'h06, 32'h0, 32'h0200_0000);
    $display("test overrun done");
    finish_test;
  end
endmodule
